/* File: logic/lioglu_consts.svh */
`ifndef LIOGLU_CONSTS_SVH
`define LIOGLU_CONSTS_SVH

`define LIOGLU_PORT_TMR0      10'h040
`define LIOGLU_PORT_TMR2      10'h042
`define LIOGLU_PORT_TMRCTL    10'h043
`define LIOGLU_PORT_TMR3      10'h044
`define LIOGLU_PORT_TMR3CTL   10'h047
`define LIOGLU_PORT_KBD_DATA  10'h060
`define LIOGLU_PORT_KBD_STAT  10'h064
`define LIOGLU_PORT_SYSB      10'h061
`define LIOGLU_PORT_CLKIDX    10'h070
`define LIOGLU_PORT_CLKDATA   10'h071
`define LIOGLU_PORT_CRAM_LO   10'h074
`define LIOGLU_PORT_CRAM_HI   10'h075
`define LIOGLU_PORT_CRAM_DAT  10'h076
`define LIOGLU_PORT_FEEDBK    10'h091
`define LIOGLU_PORT_SYSA      10'h092
`define LIOGLU_PORT_BSETUP    10'h094
`define LIOGLU_PORT_CSETUP    10'h096
`define LIOGLU_PORT_CSETUP2   10'h097
`define LIOGLU_PORT_OPTSEL    10'h102
`define LIOGLU_PORT_DISPEN    10'h3C3
`define LIOGLU_PORT_PIC1      10'h020
`define LIOGLU_PORT_PIC2      10'h0A0
`define LIOGLU_FLOPPY_BASE    7'h7E
`define LIOGLU_COM1_BASE      7'h7F
`define LIOGLU_COM2_BASE      7'h5F
`define LIOGLU_PRINTER_MAP_FIRST_BASE      8'hEF
`define LIOGLU_PRINTER_MAP_SECOND_BASE      8'hDE
`define LIOGLU_PRINTER_MAP_THIRD_BASE      8'h9E
`define LIOGLU_SECURE_LO      7'h38
`define LIOGLU_SECURE_HI      7'h3F
`define LIOGLU_BIT_DISP_SETUP 5
`define LIOGLU_BIT_DISP_EN    0
`define LIOGLU_BIT_COM_SEL    3
`define LIOGLU_BIT_LPT_LO     5
`define LIOGLU_BIT_LPT_HI     6
`define LIOGLU_BIT_BIDIR      7
`define LIOGLU_BIT_SECURE     3
`define LIOGLU_BIT_NMI_OFF    7
`define LIOGLU_BIT_ICW1       4
`define LIOGLU_RST_SYSA       8'h00
`define LIOGLU_RST_SYSB       8'h00
`define LIOGLU_RST_BSETUP     8'hFF
`define LIOGLU_RST_OPTSEL     8'h00
`define LIOGLU_RST_DISPEN     8'h01
`define LIOGLU_RST_CLKIDX     8'h80
`define LIOGLU_COPRO_RST_NS   2000
`define LIOGLU_CLK_NS         20
`define LIOGLU_COPRO_CYC      ((`LIOGLU_COPRO_RST_NS + `LIOGLU_CLK_NS - 1) / `LIOGLU_CLK_NS)
`define LIOGLU_SLOW_NS        280
`define LIOGLU_SLOW_CYC       ((`LIOGLU_SLOW_NS + `LIOGLU_CLK_NS - 1) / `LIOGLU_CLK_NS)

`endif

/* File: logic/lioglu_pkg.sv */
package lioglu_pkg;
	typedef struct packed {
		logic floppy_select_n;
		logic keyboard_select_n;
		logic printer_port_select_n;
		logic serial_select_n;
		logic timer_select_n;
		logic card_setup_rd_strobe_n;
		logic card_setup_wr_strobe;
	} lioglu_sel_t;

	typedef struct packed {
		logic clock_chip_addr_latch;
		logic clock_rd_n;
		logic clock_wr_n;
		logic cram_rd_n;
		logic cram_wr_n;
	} lioglu_ram_t;

	typedef enum logic [1:0] {
		LIOGLU_CP_IDLE    = 2'b00,
		LIOGLU_CP_STRETCH = 2'b01,
		LIOGLU_CP_DRAIN   = 2'b10
	} lioglu_cp_state_t;
endpackage

/* File: logic/lioglu_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lioglu_consts.svh"

// What this block does
// [R1] Latch bus address, drive peripheral address
// [R2] Drive transceiver controls, extend slow cycles
// [R3] Decode timer ports 40,42,43,44,47
// [R4] Floppy select for ports 3F0-3F7
// [R5] Setup port bit 5 drives display setup
// [R6] Port 3C3 bit 0 drives display enable
// [R7] Strobes for card setup ports 96-97
// [R8] Invert active-low level interrupts for controllers
// [R9] Force controllers level-sensitive on init writes
// [R10] Clock chip strobes for ports 70-71
// [R11] Ports 74/75 address RAM, 76 data
// [R12] Suppress latch for protected offsets 38-3F
// [R13] Serial decode at 3F8 or 2F8
// [R14] Printer select at 3BC, 378 or 278
// [R15] Output printer bidirectional mode enable
// [R16] Stretch coprocessor reset pulse
// [R17] Hold channel ready low during reset cycle
// [R18] Outside logic syncs stretched reset to coprocessor
// [R19] Keyboard select for ports 60 and 64
// [R20] Latch keyboard and mouse interrupts
// [R21] Write-only NMI enable plus control ports
// [R22] Asynchronous reset loads defaults into all state
// [R23] Port 102 bit 3 routes serial interrupt
// [R24] Port 102 bits 5-6 choose printer map
// [R25] Port 102 bit 7 drives bidirectional enable
// [R26] Keyboard read clears latched interrupts
// [R27] Decodes qualified by active I/O strobes
module lioglu_top (
	input  wire logic                   mclk,
	input  wire logic                   arst_n,
	input  wire logic [9:0]             bus_addr,
	input  wire logic                   address_latch_strobe_n,
	input  wire logic                   bus_status1_n,
	input  wire logic                   io_read_n,
	input  wire logic                   io_write_n,
	input  wire logic [7:0]             peripheral_data_in,
	output logic      [7:0]             peripheral_data_out,
	output logic                        peripheral_data_oe,
	output logic      [9:3]             peripheral_addr_out,
	output logic                        latched_status1_n,
	output logic                        xcvr_latch_enable_n,
	output logic                        xcvr_output_enable_n,
	output logic                        peripheral_bus_enable_n,
	output logic                        channel_ready_out,
	output lioglu_pkg::lioglu_sel_t     selects,
	output lioglu_pkg::lioglu_ram_t     ram_strobes,
	output logic      [12:0]            cram_addr,
	output logic                        display_setup_n,
	output logic                        display_enable_out,
	output logic                        printer_bidir_enable,
	input  wire logic                   serial_irq_in,
	output logic                        serial_irq_a_n,
	output logic                        serial_irq_b_n,
	input  wire logic [7:0]             card_feedback_in,
	input  wire logic [7:0]             sysb_status_in,
	input  wire logic [10:0]            bus_irq_n,
	output logic      [10:0]            pic_irq,
	output logic      [7:0]             pic_wdata,
	output logic                        pic_wr,
	output logic                        timer_wr,
	output logic                        timer_rd,
	input  wire logic                   kbd_irq_in,
	input  wire logic                   mouse_irq_in,
	output logic                        kbd_irq_latched,
	output logic                        mouse_irq_latched,
	input  wire logic                   copro_reset_request,
	output logic                        copro_reset_stretched,
	output logic                        nmi_enable_out,
	output logic      [7:0]             sysa_out,
	output logic      [7:0]             sysb_out
);
	import lioglu_pkg::*;

	localparam int unsigned COPRO_CYC = `LIOGLU_COPRO_CYC;
	localparam int unsigned SLOW_CYC  = `LIOGLU_SLOW_CYC;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: all bus inputs come from outside the mclk domain
	logic [1:0]  ale_s, rd_s, wr_s, st_s, sirq_s, kbd_s, mouse_s, cpr_s;
	logic [9:0]  a_s1, a_s2;
	logic [7:0]  d_s1, d_s2;
	logic [10:0] irq_s1, irq_s2;
	logic        rd_d, wr_d;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ale_s   <= 2'h3;
			rd_s    <= 2'h3;
			wr_s    <= 2'h3;
			st_s    <= 2'h3;
			sirq_s  <= 2'h0;
			kbd_s   <= 2'h0;
			mouse_s <= 2'h0;
			cpr_s   <= 2'h0;
			a_s1    <= 10'h000;
			a_s2    <= 10'h000;
			d_s1    <= 8'h00;
			d_s2    <= 8'h00;
			irq_s1  <= 11'h7FF;
			irq_s2  <= 11'h7FF;
			rd_d    <= 1'b0;
			wr_d    <= 1'b0;
		end else begin
			ale_s   <= {ale_s[0], address_latch_strobe_n};
			rd_s    <= {rd_s[0], io_read_n};
			wr_s    <= {wr_s[0], io_write_n};
			st_s    <= {st_s[0], bus_status1_n};
			sirq_s  <= {sirq_s[0], serial_irq_in};
			kbd_s   <= {kbd_s[0], kbd_irq_in};
			mouse_s <= {mouse_s[0], mouse_irq_in};
			cpr_s   <= {cpr_s[0], copro_reset_request};
			a_s1    <= bus_addr;
			a_s2    <= a_s1;
			d_s1    <= peripheral_data_in;
			d_s2    <= d_s1;
			irq_s1  <= bus_irq_n;
			irq_s2  <= irq_s1;
			rd_d    <= !rd_s[1];
			wr_d    <= !wr_s[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [9:0] lat_addr;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lat_addr          <= 10'h000;
			latched_status1_n <= 1'b1;
		end else if (!ale_s[1]) begin
			lat_addr          <= a_s2; // R1
			latched_status1_n <= st_s[1];
		end
	end
	assign peripheral_addr_out = lat_addr[9:3];

	wire io_rd    = !rd_s[1]; // R27
	wire io_wr    = !wr_s[1]; // R27
	wire rd_start = io_rd && !rd_d;
	wire wr_start = io_wr && !wr_d;
	wire wr_end   = !io_wr && wr_d;

	////////////////////////////////////////////////////////////////////////
	logic [7:0]  sysa_reg, sysb_reg, bsetup_reg, optsel_reg, dispen_reg;
	logic [7:0]  clkidx_reg;
	logic [12:0] cram_addr_reg;

	wire hit_sysa   = lat_addr == `LIOGLU_PORT_SYSA;
	wire hit_sysb   = lat_addr == `LIOGLU_PORT_SYSB;
	wire hit_bset   = lat_addr == `LIOGLU_PORT_BSETUP;
	wire hit_opt    = lat_addr == `LIOGLU_PORT_OPTSEL;
	wire hit_disp   = lat_addr == `LIOGLU_PORT_DISPEN;
	wire hit_fb     = lat_addr == `LIOGLU_PORT_FEEDBK;
	wire hit_cidx   = lat_addr == `LIOGLU_PORT_CLKIDX;
	wire hit_cdat   = lat_addr == `LIOGLU_PORT_CLKDATA;
	wire hit_clo    = lat_addr == `LIOGLU_PORT_CRAM_LO;
	wire hit_chi    = lat_addr == `LIOGLU_PORT_CRAM_HI;
	wire hit_cram   = lat_addr == `LIOGLU_PORT_CRAM_DAT;
	wire hit_kbd    = lat_addr == `LIOGLU_PORT_KBD_DATA
		|| lat_addr == `LIOGLU_PORT_KBD_STAT; // R19
	wire hit_tmr    = lat_addr == `LIOGLU_PORT_TMR0
		|| lat_addr == `LIOGLU_PORT_TMR2
		|| lat_addr == `LIOGLU_PORT_TMRCTL
		|| lat_addr == `LIOGLU_PORT_TMR3
		|| lat_addr == `LIOGLU_PORT_TMR3CTL; // R3
	wire hit_csu    = lat_addr == `LIOGLU_PORT_CSETUP
		|| lat_addr == `LIOGLU_PORT_CSETUP2; // R7
	wire hit_flop   = lat_addr[9:3] == `LIOGLU_FLOPPY_BASE; // R4
	wire com_second = optsel_reg[`LIOGLU_BIT_COM_SEL];
	wire hit_ser    = lat_addr[9:3] == (com_second ? `LIOGLU_COM2_BASE
		: `LIOGLU_COM1_BASE); // R13
	wire [1:0] lpt_map = optsel_reg[`LIOGLU_BIT_LPT_HI:`LIOGLU_BIT_LPT_LO];
	logic hit_lpt;
	always_comb begin
		case (lpt_map) // R24
		2'b00:   hit_lpt = lat_addr[9:2] == `LIOGLU_PRINTER_MAP_FIRST_BASE; // R14
		2'b01:   hit_lpt = lat_addr[9:2] == `LIOGLU_PRINTER_MAP_SECOND_BASE;
		2'b10:   hit_lpt = lat_addr[9:2] == `LIOGLU_PRINTER_MAP_THIRD_BASE;
		default: hit_lpt = 1'b0;
		endcase
	end
	wire hit_pic = lat_addr[9:1] == `LIOGLU_PORT_PIC1 >> 1
		|| lat_addr[9:1] == `LIOGLU_PORT_PIC2 >> 1;

	// Protected clock RAM offsets may not be selected while secured
	wire secure_hit = sysa_reg[`LIOGLU_BIT_SECURE]
		&& d_s2[6:0] >= `LIOGLU_SECURE_LO
		&& d_s2[6:0] <= `LIOGLU_SECURE_HI; // R12

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sysa_reg   <= `LIOGLU_RST_SYSA; // R22
			sysb_reg   <= `LIOGLU_RST_SYSB;
			bsetup_reg <= `LIOGLU_RST_BSETUP;
			optsel_reg <= `LIOGLU_RST_OPTSEL;
			dispen_reg <= `LIOGLU_RST_DISPEN;
			clkidx_reg <= `LIOGLU_RST_CLKIDX;
			cram_addr_reg <= 13'h0000;
		end else if (wr_end) begin
			// Data sampled at the trailing edge, where it is settled
			if (hit_sysa) sysa_reg <= d_s2; // R21
			if (hit_sysb) sysb_reg <= d_s2;
			if (hit_bset) bsetup_reg <= d_s2;
			if (hit_opt) optsel_reg <= d_s2;
			if (hit_disp) dispen_reg <= d_s2;
			if (hit_cidx) clkidx_reg <= d_s2; // R21
			if (hit_clo) cram_addr_reg[7:0] <= d_s2; // R11
			if (hit_chi) cram_addr_reg[12:8] <= d_s2[4:0]; // R11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data: port 70 is write-only and reads nothing back
	logic [7:0] rdata;
	logic       rhit;
	always_comb begin
		rhit  = 1'b1;
		rdata = 8'h00;
		if (hit_sysa) rdata = sysa_reg;
		else if (hit_sysb) rdata = {sysb_status_in[7:4], sysb_reg[3:0]};
		else if (hit_bset) rdata = bsetup_reg;
		else if (hit_opt) rdata = optsel_reg;
		else if (hit_disp) rdata = dispen_reg;
		else if (hit_fb) rdata = card_feedback_in;
		else if (hit_clo) rdata = cram_addr_reg[7:0];
		else if (hit_chi) rdata = {3'h0, cram_addr_reg[12:8]};
		else rhit = 1'b0;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			peripheral_data_out <= 8'h00;
			peripheral_data_oe  <= 1'b0;
		end else begin
			peripheral_data_out <= rdata;
			peripheral_data_oe  <= io_rd && rhit; // R27
		end
	end

	////////////////////////////////////////////////////////////////////////
	wire any_local = hit_kbd || hit_tmr || hit_csu || hit_flop || hit_ser
		|| hit_lpt || hit_pic || hit_cidx || hit_cdat || hit_cram
		|| hit_clo || hit_chi || rhit;
	wire slow_hit = hit_kbd || hit_cidx || hit_cdat || hit_ser;
	wire cmd = io_rd || io_wr;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			selects     <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
			ram_strobes <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
			timer_wr    <= 1'b0;
			timer_rd    <= 1'b0;
			pic_wr      <= 1'b0;
			pic_wdata   <= 8'h00;
		end else begin
			selects.floppy_select_n        <= !(cmd && hit_flop); // R4
			selects.keyboard_select_n      <= !(cmd && hit_kbd); // R19
			selects.printer_port_select_n  <= !(cmd && hit_lpt); // R14
			selects.serial_select_n        <= !(cmd && hit_ser); // R13
			selects.timer_select_n         <= !(cmd && hit_tmr); // R3
			selects.card_setup_rd_strobe_n <= !(io_rd && hit_csu); // R7
			selects.card_setup_wr_strobe   <= io_wr && hit_csu; // R7
			ram_strobes.clock_chip_addr_latch <= io_wr && hit_cidx
				&& !secure_hit; // R10 R12
			ram_strobes.clock_rd_n <= !(io_rd && hit_cdat); // R10
			ram_strobes.clock_wr_n <= !(io_wr && hit_cdat); // R10
			ram_strobes.cram_rd_n  <= !(io_rd && hit_cram); // R11
			ram_strobes.cram_wr_n  <= !(io_wr && hit_cram); // R11
			timer_wr <= wr_start && hit_tmr; // R3
			timer_rd <= rd_start && hit_tmr;
			pic_wr   <= wr_start && hit_pic;
			// An init word always carries the level-trigger bit
			pic_wdata <= (!lat_addr[0] && d_s2[`LIOGLU_BIT_ICW1])
				? (d_s2 | 8'h08) : d_s2; // R9
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [4:0] slow_cnt;
	logic       cp_hold;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			slow_cnt <= 5'h00;
		end else if ((rd_start || wr_start) && slow_hit) begin
			slow_cnt <= 5'(SLOW_CYC); // R2
		end else if (slow_cnt != 5'h00) begin
			slow_cnt <= slow_cnt - 5'h01;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			xcvr_latch_enable_n     <= 1'b1;
			xcvr_output_enable_n    <= 1'b1;
			peripheral_bus_enable_n <= 1'b1;
			channel_ready_out       <= 1'b1;
		end else begin
			xcvr_latch_enable_n     <= !(io_wr && any_local); // R2
			xcvr_output_enable_n    <= !(io_rd && any_local); // R2
			peripheral_bus_enable_n <= !(cmd && any_local);
			channel_ready_out <= !(cp_hold
				|| (slow_cnt > 5'h01)
				|| ((rd_start || wr_start) && slow_hit)); // R2 R17
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Coprocessor reset stretcher; the output must be resynchronised
	// outside to the coprocessor clock before use (R18)
	lioglu_cp_state_t cp_state;
	logic [6:0]       cp_cnt;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cp_state              <= LIOGLU_CP_IDLE;
			cp_cnt                <= 7'h00;
			copro_reset_stretched <= 1'b0;
			cp_hold               <= 1'b0;
		end else begin
			case (cp_state)
			LIOGLU_CP_IDLE: begin
				if (cpr_s[1]) begin
					cp_state              <= LIOGLU_CP_STRETCH;
					cp_cnt                <= 7'(COPRO_CYC);
					copro_reset_stretched <= 1'b1; // R16
					cp_hold               <= 1'b1; // R17
				end
			end
			LIOGLU_CP_STRETCH: begin
				if (cp_cnt != 7'h00) begin
					cp_cnt <= cp_cnt - 7'h01;
				end else begin
					copro_reset_stretched <= 1'b0;
					cp_cnt                <= 7'(COPRO_CYC);
					cp_state              <= LIOGLU_CP_DRAIN;
				end
			end
			LIOGLU_CP_DRAIN: begin
				// Init time after reset before the CPU is let go
				if (cp_cnt != 7'h00) begin
					cp_cnt <= cp_cnt - 7'h01;
				end else if (!cpr_s[1]) begin
					cp_hold  <= 1'b0;
					cp_state <= LIOGLU_CP_IDLE;
				end
			end
			default: cp_state <= LIOGLU_CP_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pic_irq           <= 11'h000;
			serial_irq_a_n    <= 1'b1;
			serial_irq_b_n    <= 1'b1;
			kbd_irq_latched   <= 1'b0;
			mouse_irq_latched <= 1'b0;
		end else begin
			pic_irq        <= ~irq_s2; // R8
			serial_irq_a_n <= !(sirq_s[1] && !com_second); // R23
			serial_irq_b_n <= !(sirq_s[1] && com_second); // R23
			// A new request beats the clear in the same cycle
			kbd_irq_latched <= kbd_s[1]
				|| (kbd_irq_latched && !(rd_start && hit_kbd)); // R20 R26
			mouse_irq_latched <= mouse_s[1]
				|| (mouse_irq_latched && !(rd_start && hit_kbd)); // R20 R26
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			display_setup_n      <= 1'b1;
			display_enable_out   <= 1'b1;
			printer_bidir_enable <= 1'b0;
			nmi_enable_out       <= 1'b0;
			cram_addr            <= 13'h0000;
			sysa_out             <= `LIOGLU_RST_SYSA;
			sysb_out             <= `LIOGLU_RST_SYSB;
		end else begin
			display_setup_n      <= bsetup_reg[`LIOGLU_BIT_DISP_SETUP]; // R5
			display_enable_out   <= dispen_reg[`LIOGLU_BIT_DISP_EN]; // R6
			printer_bidir_enable <= optsel_reg[`LIOGLU_BIT_BIDIR]; // R15 R25
			nmi_enable_out <= !clkidx_reg[`LIOGLU_BIT_NMI_OFF]; // R21
			cram_addr            <= cram_addr_reg; // R11
			sysa_out             <= sysa_reg;
			sysb_out             <= sysb_reg;
		end
	end
endmodule
`default_nettype wire

/* File: tb/lioglu_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lioglu_consts.svh"
module lioglu_top_asserts (
	input wire logic                    mclk,
	input wire logic                    arst_n,
	input wire logic                    io_read_n,
	input wire logic                    io_write_n,
	input wire logic [7:0]              peripheral_data_in,
	input wire logic [9:3]              peripheral_addr_out,
	input wire logic                    channel_ready_out,
	input wire lioglu_pkg::lioglu_sel_t selects,
	input wire lioglu_pkg::lioglu_ram_t ram_strobes,
	input wire logic [10:0]             bus_irq_n,
	input wire logic [10:0]             pic_irq,
	input wire logic                    kbd_irq_in,
	input wire logic                    mouse_irq_in,
	input wire logic                    kbd_irq_latched,
	input wire logic                    mouse_irq_latched,
	input wire logic                    copro_reset_stretched,
	input wire logic [7:0]              sysa_out
);
	localparam int COPRO_MIN = `LIOGLU_COPRO_CYC;
	int unsigned cp_len;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////////////
	// Stretch length; too long to unroll
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			cp_len <= 0;
		else
			cp_len <= copro_reset_stretched ? cp_len + 1 : 0;
	end
	////////////////////////////////////////////////////////////////////////
	property p_idle_quiet;
		(io_read_n && io_write_n)[*5] |-> selects.floppy_select_n &&
			selects.keyboard_select_n && selects.timer_select_n &&
			!selects.card_setup_wr_strobe &&
			!ram_strobes.clock_chip_addr_latch;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("select active with no command");
	property p_floppy;
		!selects.floppy_select_n |-> peripheral_addr_out == 7'h7E;
	endproperty
	a_floppy: assert property (p_floppy)
		else $error("floppy select outside its range");
	property p_kbd_sel;
		!selects.keyboard_select_n |-> peripheral_addr_out == 7'h0C;
	endproperty
	a_kbd_sel: assert property (p_kbd_sel)
		else $error("keyboard select outside its ports");
	property p_timer;
		!selects.timer_select_n |-> peripheral_addr_out == 7'h08;
	endproperty
	a_timer: assert property (p_timer)
		else $error("timer select outside its ports");
	property p_irq_inv;
		$stable(bus_irq_n)[*5] |-> pic_irq == ~bus_irq_n;
	endproperty
	a_irq_inv: assert property (p_irq_inv)
		else $error("controller request not inverse of bus line");
	property p_secure;
		ram_strobes.clock_chip_addr_latch |->
			!(sysa_out[3] && peripheral_data_in[6:3] == 4'h7);
	endproperty
	a_secure: assert property (p_secure)
		else $error("protected clock offset latched");
	property p_kbd_set;
		$rose(kbd_irq_in) |-> ##[1:4] kbd_irq_latched;
	endproperty
	a_kbd_set: assert property (p_kbd_set)
		else $error("keyboard request not latched");
	property p_kbd_clr;
		!selects.keyboard_select_n && !io_read_n && !kbd_irq_in &&
			!mouse_irq_in |-> ##[1:6] !kbd_irq_latched && !mouse_irq_latched;
	endproperty
	a_kbd_clr: assert property (p_kbd_clr)
		else $error("keyboard read left requests latched");
	property p_copro_len;
		$fell(copro_reset_stretched) |-> cp_len >= COPRO_MIN;
	endproperty
	a_copro_len: assert property (p_copro_len)
		else $error("coprocessor reset too short");
	property p_copro_rdy;
		$rose(copro_reset_stretched) |-> ##[0:4] !channel_ready_out;
	endproperty
	a_copro_rdy: assert property (p_copro_rdy)
		else $error("ready not held off for coprocessor reset");
	property p_ready_bound;
		$fell(channel_ready_out) |-> ##[1:400] channel_ready_out;
	endproperty
	a_ready_bound: assert property (p_ready_bound)
		else $error("cycle extension never ends");
	c_floppy: cover property (!selects.floppy_select_n);
	c_copro: cover property ($fell(copro_reset_stretched));
	c_kbd: cover property ($rose(kbd_irq_latched));
endmodule
bind lioglu_top lioglu_top_asserts u_chk (.*);
`default_nettype wire

/* File: tb/lioglu_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lioglu_host_model (
	input  wire logic       mclk,
	input  wire logic       channel_ready_out,
	input  wire logic [7:0] peripheral_data_out,
	input  wire logic       peripheral_data_oe,
	output var  logic [9:0] bus_addr,
	output var  logic       address_latch_strobe_n,
	output var  logic       bus_status1_n,
	output var  logic       io_read_n,
	output var  logic       io_write_n,
	output var  logic [7:0] peripheral_data_in
);
	initial begin
		bus_addr = 10'h000;
		address_latch_strobe_n = 1'b1;
		bus_status1_n = 1'b1;
		io_read_n = 1'b1;
		io_write_n = 1'b1;
		peripheral_data_in = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	// Slow ports hold ready low; wait it out
	task automatic io(input logic wr, input logic [9:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic oe);
		int n;
		@(posedge mclk);
		bus_addr <= a;
		bus_status1_n <= wr;
		peripheral_data_in <= d;
		address_latch_strobe_n <= 1'b0;
		repeat (3) @(posedge mclk);
		address_latch_strobe_n <= 1'b1;
		@(posedge mclk);
		io_write_n <= !wr;
		io_read_n <= wr;
		repeat (8) @(posedge mclk);
		n = 0;
		while (channel_ready_out !== 1'b1 && n < 400) begin
			@(posedge mclk);
			n++;
		end
		q = peripheral_data_out;
		oe = peripheral_data_oe;
		io_read_n <= 1'b1;
		io_write_n <= 1'b1;
		repeat (4) @(posedge mclk);
		// Released lines show the inverse
		bus_addr <= ~a;
		peripheral_data_in <= ~d;
		repeat (2) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lioglu_pkg::*;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic [9:0]  bus_addr;
	logic        address_latch_strobe_n, bus_status1_n, io_read_n;
	logic        io_write_n, peripheral_data_oe, latched_status1_n;
	logic [7:0]  peripheral_data_in, peripheral_data_out, pic_wdata;
	logic [7:0]  sysa_out, q, pic_seen;
	logic [9:3]  peripheral_addr_out;
	logic        channel_ready_out, display_setup_n, display_enable_out;
	logic        printer_bidir_enable, serial_irq_a_n, serial_irq_b_n;
	logic        serial_irq_in = 1'b0, kbd_irq_in = 1'b0, oe, pic_wr;
	logic        mouse_irq_in = 1'b0, copro_reset_request = 1'b0;
	logic        kbd_irq_latched, mouse_irq_latched, nmi_enable_out;
	logic        copro_reset_stretched, rdy_acc;
	lioglu_sel_t selects;
	lioglu_ram_t ram_strobes;
	logic [12:0] cram_addr;
	logic [10:0] bus_irq_n = 11'h7FF, pic_irq;
	logic [6:0]  sel_acc, es;
	logic [4:0]  ram_acc;
	int          cp_hi, num_errors = 0, n_checks = 0;
	logic [7:0]  opts [4] = '{8'h00, 8'hA8, 8'h40, 8'h60};
	logic [7:0]  offs [5] = '{8'h37, 8'h38, 8'h3F, 8'h40, 8'hB8};
	logic [9:0]  addrs [21] = '{10'h3F0, 10'h3F7, 10'h3EF, 10'h3F8,
		10'h3FF, 10'h2F8, 10'h2FF, 10'h3BC, 10'h3BF, 10'h378, 10'h37B,
		10'h278, 10'h27B, 10'h060, 10'h064, 10'h063, 10'h040, 10'h047,
		10'h045, 10'h096, 10'h097};

	always #10 mclk = ~mclk;

	lioglu_top DUT (.*, .xcvr_latch_enable_n(), .xcvr_output_enable_n(),
		.peripheral_bus_enable_n(), .card_feedback_in(8'h5A),
		.sysb_status_in(8'h00), .timer_wr(), .timer_rd(), .sysb_out());

	lioglu_host_model host (.*);

	////////////////////////////////////////////////////////////////////////
	// All seen in an access, as active low
	always @(posedge mclk) begin
		sel_acc <= sel_acc & (selects ^ 7'h01);
		ram_acc <= ram_acc & (ram_strobes ^ 5'h10);
		rdy_acc <= rdy_acc & channel_ready_out;
		if (pic_wr === 1'b1)
			pic_seen <= pic_wdata;
		cp_hi <= cp_hi + int'(copro_reset_stretched === 1'b1);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: got %h, expected %h",
				$time, got, exp);
		end
	endtask

	// Cleared off the accumulating edge
	task automatic cyc(input logic wr, input logic [9:0] a,
		input logic [7:0] d);
		@(negedge mclk);
		sel_acc = 7'h7F;
		ram_acc = 5'h1F;
		rdy_acc = 1'b1;
		host.io(wr, a, d, q, oe);
		@(negedge mclk);
	endtask

	function automatic logic [6:0] exp_sel(input logic [9:0] a,
		input logic [7:0] o);
		logic [6:0] e;
		e = 7'h7F;
		e[6] = a[9:3] != 7'h7E;
		e[5] = a != 10'h060 && a != 10'h064;
		e[4] = &o[6:5] || a[9:2] != (o[6] ? 8'h9E : o[5] ? 8'hDE : 8'hEF);
		e[3] = a[9:3] != (o[3] ? 7'h5F : 7'h7F);
		e[2] = !(a inside {10'h040, 10'h042, 10'h043, 10'h044, 10'h047});
		e[1] = a[9:1] != 9'h04B;
		return e;
	endfunction

	task automatic report_and_stop;
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Over sixteen times the expected 3000 cycles
	initial begin
		#1000000;
		num_errors++;
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(negedge mclk);
		chk({display_enable_out, display_setup_n, nmi_enable_out,
			peripheral_data_oe, channel_ready_out, selects, ram_strobes},
			17'h19FCF);
		foreach (opts[i]) begin
			cyc(1'b1, 10'h102, opts[i]);
			cyc(1'b0, 10'h102, 8'h00);
			chk({oe, q, printer_bidir_enable}, {1'b1, opts[i], opts[i][7]});
			@(posedge mclk) serial_irq_in <= 1'b1;
			repeat (5) @(negedge mclk);
			chk({serial_irq_a_n, serial_irq_b_n}, {opts[i][3], !opts[i][3]});
			@(posedge mclk) serial_irq_in <= 1'b0;
			foreach (addrs[j]) begin
				cyc(1'b0, addrs[j], 8'h00);
				es = exp_sel(addrs[j], opts[i]);
				chk(sel_acc, es);
				chk({rdy_acc, peripheral_addr_out, latched_status1_n},
					{es[5] & es[3], addrs[j][9:3], 1'b0});
			end
		end
		cyc(1'b1, 10'h097, 8'h00);
		chk(sel_acc, 7'h7E);
		cyc(1'b1, 10'h094, 8'hDF);
		chk(display_setup_n, 1'b0);
		cyc(1'b1, 10'h3C3, 8'h00);
		chk(display_enable_out, 1'b0);
		cyc(1'b1, 10'h070, 8'h05);
		chk({ram_acc[4], nmi_enable_out}, 2'b01);
		cyc(1'b0, 10'h070, 8'h00);
		chk(oe, 1'b0);
		cyc(1'b0, 10'h071, 8'h00);
		chk(ram_acc, 5'h17);
		for (int s = 1; s >= 0; s--) begin
			cyc(1'b1, 10'h092, s ? 8'h08 : 8'h00);
			foreach (offs[k]) begin
				cyc(1'b1, 10'h070, offs[k]);
				chk(ram_acc[4], s == 1 && offs[k][6:3] == 4'h7);
			end
		end
		cyc(1'b1, 10'h074, 8'hAB);
		cyc(1'b1, 10'h075, 8'h1F);
		chk(cram_addr, 13'h1FAB);
		cyc(1'b0, 10'h076, 8'h00);
		chk(ram_acc, 5'h1D);
		cyc(1'b1, 10'h020, 8'h13);
		chk(pic_seen, 8'h1B);
		cyc(1'b1, 10'h021, 8'h07);
		chk(pic_seen, 8'h07);
		@(posedge mclk) bus_irq_n <= 11'h5FE;
		repeat (6) @(negedge mclk);
		chk(pic_irq, 11'h201);
		@(posedge mclk) kbd_irq_in <= 1'b1;
		mouse_irq_in <= 1'b1;
		repeat (2) @(posedge mclk);
		kbd_irq_in <= 1'b0;
		mouse_irq_in <= 1'b0;
		repeat (5) @(negedge mclk);
		chk({kbd_irq_latched, mouse_irq_latched}, 2'b11);
		cyc(1'b0, 10'h064, 8'h00);
		chk({kbd_irq_latched, mouse_irq_latched}, 2'b00);
		cp_hi = 0;
		@(posedge mclk) copro_reset_request <= 1'b1;
		repeat (2) @(posedge mclk);
		copro_reset_request <= 1'b0;
		repeat (50) @(negedge mclk);
		chk(channel_ready_out, 1'b0);
		repeat (250) @(negedge mclk);
		chk(cp_hi, 32'h00000065);
		report_and_stop();
	end
endmodule
`default_nettype wire
